//--- shared/pmr_pkg.sv
package pmr_pkg;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 5;
  localparam int PAGE_W = 7;
  localparam logic [4:0] ADDR_PEAK_I = 5'h16;
  localparam logic [4:0] ADDR_PEAK_V = 5'h17;
  localparam logic [4:0] ADDR_TRIG_REACTIVE_POWER = 5'h18;
  localparam logic [4:0] ADDR_PFACT = 5'h19;
  localparam logic [4:0] ADDR_APPAR = 5'h1B;
  localparam logic [4:0] ADDR_CTRL = 5'h1C;
  localparam logic [4:0] ADDR_PHARM = 5'h1D;
  localparam logic [4:0] ADDR_PFUND = 5'h1E;
  localparam logic [4:0] ADDR_QFUND = 5'h1F;
  localparam logic [4:0] ADDR_PAGE = 5'h1F;
  localparam int CTRL_HALT_BIT = 8;
  localparam int CTRL_DRAIN_BIT = 4;
  localparam int CTRL_NOCLK_BIT = 2;
  localparam int CTRL_OSCILLATOR_DISABLE_BIT = 1;
  localparam logic [23:0] CTRL_RESET = 24'h000000;
  localparam logic [23:0] CTRL_MASK = 24'h000116;
  localparam logic [6:0] PAGE_RESET = 7'h00;
  localparam logic [23:0] ZERO24 = 24'h000000;
  localparam logic [23:0] FRAC_MAX = 24'h7FFFFF;
  localparam logic [23:0] FRAC_MIN = 24'h800000;
  localparam logic [23:0] UFRAC_MAX = 24'hFFFFFF;
  localparam int DIV_STEPS = 24;
  localparam logic [4:0] DIV_CNT_RESET = 5'h00;
  localparam int CLKDIV_W = 1;
  typedef enum logic [1:0] {
    PMR_IDLE = 2'b00,
    PMR_DIV = 2'b01,
    PMR_LOAD = 2'b10
  } pmr_state_t;
endpackage

//--- shared/pmr_res_if.sv
interface pmr_res_if;
  import pmr_pkg::*;
  logic start;
  logic [23:0] num;
  logic [23:0] den;
  logic [23:0] quot;
  logic done;
  modport master(output start, output num, output den, input quot, input done);
  modport slave(input start, input num, input den, output quot, output done);
endinterface

//--- core/pmr_peak.sv
module pmr_peak
  import pmr_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  input wire logic cycle_end,
  output logic [W-1:0] peak
);
  typedef struct packed {
    logic [W-1:0] track;
    logic [W-1:0] peak;
  } pmr_peak_st_t;
  pmr_peak_st_t st_reg, st_next;
  function automatic logic [W-1:0] mag(input logic [W-1:0] v);
    mag = v[W-1] ? (~v + 1'b1) : v;
  endfunction
  always_comb begin
    st_next = st_reg;
    if (sample_valid && (mag(sample) > mag(st_next.track)))
      st_next.track = sample;
    if (cycle_end) begin
      st_next.peak = st_next.track;
      st_next.track = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign peak = st_reg.peak;
endmodule

//--- core/pmr_divider.sv
module pmr_divider
  import pmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  pmr_res_if.slave div
);
  typedef struct packed {
    pmr_state_t state;
    logic neg;
    logic [24:0] rem;
    logic [23:0] dvs;
    logic [23:0] q;
    logic [4:0] cnt;
    logic [23:0] quot;
    logic done;
  } pmr_div_st_t;
  pmr_div_st_t st_reg, st_next;
  logic [25:0] trial;
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    // Extra top bit keeps a doubled remainder from reading as a borrow
    trial = {1'b0, st_reg.rem[23:0], 1'b0} - {2'b00, st_reg.dvs};
    case (st_reg.state)
      PMR_IDLE: begin
        if (div.start) begin
          st_next.neg = div.num[23];
          st_next.q = div.num[23] ? (~div.num + 24'h000001) : div.num;
          st_next.rem = {1'b0, st_next.q};
          st_next.dvs = div.den;
          st_next.cnt = DIV_CNT_RESET;
          // A ratio of one or more is no fraction: mark it, skip the loop
          if (st_next.q >= div.den) begin
            st_next.q = UFRAC_MAX;
            st_next.state = PMR_LOAD;
          end else begin
            st_next.state = PMR_DIV;
          end
        end
      end
      PMR_DIV: begin
        if (!trial[25]) begin
          st_next.rem = trial[24:0];
          st_next.q = {st_reg.q[22:0], 1'b1};
        end else begin
          st_next.rem = {st_reg.rem[23:0], 1'b0};
          st_next.q = {st_reg.q[22:0], 1'b0};
        end
        st_next.cnt = st_reg.cnt + 5'h01;
        if (st_reg.cnt == 5'(DIV_STEPS - 1))
          st_next.state = PMR_LOAD;
      end
      PMR_LOAD: begin
        // Both operands Q1.23: quotient is ratio times 2^24, halved to Q1.23
        if (st_reg.dvs == ZERO24)
          st_next.quot = ZERO24;
        else if (st_reg.q == UFRAC_MAX)
          st_next.quot = st_reg.neg ? FRAC_MIN : FRAC_MAX;
        else
          st_next.quot = st_reg.neg ? (~{1'b0, st_reg.q[23:1]} + 24'h000001)
                                    : {1'b0, st_reg.q[23:1]};
        st_next.done = 1'b1;
        st_next.state = PMR_IDLE;
      end
      default: st_next.state = PMR_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign div.quot = st_reg.quot;
  assign div.done = st_reg.done;
endmodule

//--- core/pmr_result_regs.sv
module pmr_result_regs
  import pmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_wdata,
  output logic [pmr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sample_valid,
  input wire logic [pmr_pkg::DATA_W-1:0] inst_current,
  input wire logic [pmr_pkg::DATA_W-1:0] inst_voltage,
  input wire logic cycle_end,
  input wire logic [pmr_pkg::DATA_W-1:0] rms_voltage,
  input wire logic [pmr_pkg::DATA_W-1:0] rms_current,
  input wire logic [pmr_pkg::DATA_W-1:0] active_power,
  input wire logic [pmr_pkg::DATA_W-1:0] dft_v_re,
  input wire logic [pmr_pkg::DATA_W-1:0] dft_v_im,
  input wire logic [pmr_pkg::DATA_W-1:0] dft_i_re,
  input wire logic [pmr_pkg::DATA_W-1:0] dft_i_im,
  input wire logic irq_request,
  input wire logic osc_clock,
  output logic autoboot_halt,
  output logic irq_out,
  output logic irq_oe,
  output logic processor_clock_out,
  output logic processor_clock_oe,
  output logic oscillator_enable,
  output logic [pmr_pkg::PAGE_W-1:0] page_select
);
  import pmr_pkg::*;

  // ************************************
  // State
  // ************************************
  typedef struct packed {
    logic [23:0] trig_reactive_power;
    logic [23:0] apparent_power_result;
    logic [23:0] harmonic_active_power;
    logic [23:0] fundamental_active_power;
    logic [23:0] fundamental_reactive_power;
    logic [23:0] power_factor_result;
    logic [23:0] pend_active;
    logic [23:0] device_control;
    logic [6:0] register_page_select;
    logic [23:0] rdata;
    logic rvalid;
    logic div_start;
  } pmr_top_st_t;
  pmr_top_st_t st_reg, st_next;

  logic [23:0] peak_current_capture;
  logic [23:0] peak_voltage_capture;
  pmr_res_if div_bus();

  // Signed Q1.23 product, rounded toward minus infinity by truncation
  function automatic logic [23:0] smul(input logic [23:0] a, input logic [23:0] b);
    logic [47:0] p;
    p = 48'($signed(a) * $signed(b));
    smul = p[46:23];
  endfunction

  // Saturating signed Q1.23 add
  function automatic logic [23:0] sadd(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    s = {a[23], a} + {b[23], b};
    if (s[24] != s[23])
      sadd = s[24] ? FRAC_MIN : FRAC_MAX;
    else
      sadd = s[23:0];
  endfunction

  function automatic logic [23:0] umul(input logic [23:0] a, input logic [23:0] b);
    logic [47:0] p;
    p = 48'(a * b);
    // Q0.24 product brought to Q1.23, so the top bit stays clear
    umul = {1'b0, p[47:25]};
  endfunction

  // Square root of a 48-bit value, bitwise restoring
  function automatic logic [23:0] usqrt(input logic [47:0] v);
    logic [23:0] r;
    logic [23:0] t;
    r = '0;
    for (int k = 23; k >= 0; k--) begin
      t = r | (24'h000001 << k);
      if (48'(t * t) <= v)
        r = t;
    end
    usqrt = r;
  endfunction

  // ************************************
  // Peak capture
  // ************************************
  pmr_peak #(.W(DATA_W)) u_peak_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .sample_valid(sample_valid),
    .sample(inst_current),
    .cycle_end(cycle_end),
    .peak(peak_current_capture)
  );

  pmr_peak #(.W(DATA_W)) u_peak_v (
    .clk_sys(clk_sys),
    .reset(reset),
    .sample_valid(sample_valid),
    .sample(inst_voltage),
    .cycle_end(cycle_end),
    .peak(peak_voltage_capture)
  );

  // ************************************
  // Power factor divider
  // ************************************
  pmr_divider u_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .div(div_bus)
  );

  logic [23:0] s_now;
  logic [23:0] pf_fund;
  logic [23:0] qf_fund;
  logic [47:0] q_sq;
  logic [23:0] p_mag;

  always_comb begin
    s_now = umul(rms_voltage, rms_current);
    pf_fund = sadd(smul(dft_v_re, dft_i_re), smul(dft_v_im, dft_i_im));
    qf_fund = sadd(smul(dft_v_im, dft_i_re), ~smul(dft_v_re, dft_i_im) + 24'h000001);
    // Q from S squared minus P squared
    // S and P share the Q1.23 scale; a negative radicand floors at zero
    p_mag = active_power[23] ? (~active_power + 24'h000001) : active_power;
    if (48'(s_now * s_now) > 48'(p_mag * p_mag))
      q_sq = 48'(s_now * s_now) - 48'(p_mag * p_mag);
    else
      q_sq = 48'h000000000000;
  end

  assign div_bus.start = st_reg.div_start;
  assign div_bus.num = st_reg.pend_active;
  assign div_bus.den = st_reg.apparent_power_result;

  // ************************************
  // Next state
  // ************************************
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.div_start = 1'b0;
    if (cycle_end) begin
      st_next.apparent_power_result = s_now;
      st_next.trig_reactive_power = usqrt(q_sq);
      st_next.fundamental_active_power = pf_fund;
      st_next.fundamental_reactive_power = qf_fund;
      st_next.harmonic_active_power = sadd(active_power, ~pf_fund + 24'h000001);
      st_next.pend_active = active_power;
      st_next.div_start = 1'b1;
    end
    if (div_bus.done)
      st_next.power_factor_result = div_bus.quot;
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL)
        st_next.device_control = reg_wdata & CTRL_MASK;
      if (reg_addr == ADDR_PAGE)
        st_next.register_page_select = reg_wdata[6:0];
    end
    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      case (reg_addr)
        ADDR_PEAK_I: st_next.rdata = peak_current_capture;
        ADDR_PEAK_V: st_next.rdata = peak_voltage_capture;
        ADDR_TRIG_REACTIVE_POWER: st_next.rdata = st_reg.trig_reactive_power;
        ADDR_PFACT: st_next.rdata = st_reg.power_factor_result;
        ADDR_APPAR: st_next.rdata = st_reg.apparent_power_result;
        ADDR_CTRL: st_next.rdata = st_reg.device_control;
        ADDR_PHARM: st_next.rdata = st_reg.harmonic_active_power;
        ADDR_PFUND: st_next.rdata = st_reg.fundamental_active_power;
        ADDR_QFUND: st_next.rdata = st_reg.fundamental_reactive_power;
        default: st_next.rdata = ZERO24;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.device_control <= CTRL_RESET;
      st_reg.register_page_select <= PAGE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************
  // Pin control
  // ************************************
  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign page_select = st_reg.register_page_select;
  assign autoboot_halt = st_reg.device_control[CTRL_HALT_BIT];
  assign irq_out = st_reg.device_control[CTRL_DRAIN_BIT] ? 1'b0 : irq_request;
  assign irq_oe = st_reg.device_control[CTRL_DRAIN_BIT] ? irq_request : 1'b1;
  assign processor_clock_out = st_reg.device_control[CTRL_NOCLK_BIT] ? 1'b0 : osc_clock;
  assign processor_clock_oe = ~st_reg.device_control[CTRL_NOCLK_BIT];
  assign oscillator_enable = ~st_reg.device_control[CTRL_OSCILLATOR_DISABLE_BIT];
endmodule

//--- verification/pmr_result_regs_monitor.sv
module pmr_result_regs_monitor
  import pmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq_request,
  input wire logic osc_clock,
  input wire logic autoboot_halt,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic processor_clock_out,
  input wire logic processor_clock_oe,
  input wire logic oscillator_enable,
  input wire logic [pmr_pkg::PAGE_W-1:0] page_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****************
  // Properties
  // ****************
  property p_ctrl_rd;
    reg_rd && reg_addr == ADDR_CTRL |=> (reg_rdata & ~CTRL_MASK) == ZERO24;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback has unused bits set");
  property p_halt;
    reg_wr && reg_addr == ADDR_CTRL |=> autoboot_halt == $past(reg_wdata[CTRL_HALT_BIT]);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt output does not follow control write");
  property p_osc;
    reg_wr && reg_addr == ADDR_CTRL |=> oscillator_enable == !$past(reg_wdata[CTRL_OSCILLATOR_DISABLE_BIT]);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable does not follow control write");
  property p_clk_off;
    !processor_clock_oe |-> !processor_clock_out;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("clock pin toggles while disabled");
  property p_clk_on;
    processor_clock_oe |-> processor_clock_out == osc_clock;
  endproperty
  a_clk_on: assert property (p_clk_on)
    else $error("clock pin does not forward oscillator");
  property p_irq_off;
    !irq_oe |-> !irq_request && !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt pin released while request high");
  property p_irq_on;
    irq_oe && irq_out |-> irq_request;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupt pin high without request");
  property p_page;
    reg_wr && reg_addr == ADDR_PAGE |=> page_select == $past(reg_wdata[PAGE_W-1:0]);
  endproperty
  a_page: assert property (p_page)
    else $error("page select not loaded");
  property p_page_hold;
    !(reg_wr && reg_addr == ADDR_PAGE) |=> $stable(page_select);
  endproperty
  a_page_hold: assert property (p_page_hold)
    else $error("page select changed without write");
  property p_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered next cycle");
endmodule

bind pmr_result_regs pmr_result_regs_monitor u_mon (.clk_sys, .reset, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .irq_request, .osc_clock, .autoboot_halt,
  .irq_out, .irq_oe, .processor_clock_out, .processor_clock_oe, .oscillator_enable,
  .page_select);

//--- verification/pmr_host_model.sv
module pmr_host_model
  import pmr_pkg::*;
(
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [pmr_pkg::ADDR_W-1:0] reg_addr,
  output logic [pmr_pkg::DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end
  // ****************
  // Word transfer
  // ****************
  // One word per request
  task automatic xfer(input logic w, input logic [4:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines must not keep the old value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

//--- verification/test_power_meter_result_regs.sv
module test_power_meter_result_regs
  import pmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, reg_wr, reg_rd, reg_rvalid, sample_valid = 0, cycle_end = 0;
  logic irq_request = 0, osc_clock = 0, autoboot_halt, irq_out, irq_oe;
  logic processor_clock_out, processor_clock_oe, oscillator_enable;
  logic [4:0] reg_addr;
  logic [6:0] page_select, p;
  logic [23:0] reg_wdata, reg_rdata, w, inst_current = 0, inst_voltage = 0;
  logic [23:0] rms_voltage = 0, rms_current = 0, active_power = 0;
  logic [23:0] dft_v_re = 0, dft_v_im = 0, dft_i_re = 0, dft_i_im = 0;
  logic [23:0] e, q[$];
  int n_errors = 0, check_count = 0, cycles = 0;
  pmr_result_regs u_dut (.clk_sys, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .sample_valid, .inst_current, .inst_voltage, .cycle_end,
    .rms_voltage, .rms_current, .active_power, .dft_v_re, .dft_v_im, .dft_i_re, .dft_i_im,
    .irq_request, .osc_clock, .autoboot_halt, .irq_out, .irq_oe, .processor_clock_out,
    .processor_clock_oe, .oscillator_enable, .page_select);
  pmr_host_model u_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
    #1 osc_clock = 1'($urandom_range(0, 1));
  end
  // ****************
  // Helpers
  // ****************
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] x);
    q.push_back(x);
    u_host.xfer(1'b0, a, 24'h000000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  function automatic int mag(input logic signed [23:0] x);
    return (x < 0) ? -int'(x) : int'(x);
  endfunction
  // Feeds n samples; sh shrinks them so a stale peak would show
  task automatic peaks(input int n, input int sh);
    logic signed [23:0] ci, vi, bi, bv;
    bi = 0;
    bv = 0;
    for (int k = 0; k < n; k++) begin
      ci = 24'($urandom_range(0, 8388607) - 4194304) >>> sh;
      vi = 24'($urandom_range(0, 8388607) - 4194304) >>> sh;
      if (mag(ci) > mag(bi)) bi = ci;
      if (mag(vi) > mag(bv)) bv = vi;
      @(posedge clk_sys);
      #1;
      sample_valid = 1;
      inst_current = ci;
      inst_voltage = vi;
      cycle_end = (k == n - 1);
    end
    @(posedge clk_sys);
    #1;
    sample_valid = 0;
    cycle_end = 0;
    rd(ADDR_PEAK_I, bi);
    rd(ADDR_PEAK_V, bv);
  endtask
  // ****************
  // Read answer checker
  // ****************
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "unexpected read answer");
      else begin
        e = q.pop_front();
        chk(reg_rdata === e, "read data");
      end
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(83));
    repeat (2) @(posedge clk_sys);
    #1 reset = 0;
    chk(autoboot_halt === 0 && irq_oe === 1 && oscillator_enable === 1, "reset pins");
    chk(page_select === PAGE_RESET, "page reset");
    rd(ADDR_CTRL, CTRL_RESET);
    for (int c = 0; c < 8; c++) begin
      w = 24'($urandom);
      w[8] = c[0];
      w[4] = c[1];
      w[2] = c[2];
      w[1] = c[1] ^ c[2];
      wr(ADDR_CTRL, w);
      rd(ADDR_CTRL, w & CTRL_MASK);
      // The clock pin follows osc_clock combinationally; look mid-cycle, once settled
      @(negedge clk_sys);
      chk(autoboot_halt === w[8], "halt");
      chk(oscillator_enable === !w[1], "oscillator");
      chk(processor_clock_oe === !w[2], "clock enable");
      chk(processor_clock_out === (w[2] ? 1'b0 : osc_clock), "clock out");
      for (int r = 0; r < 2; r++) begin
        @(posedge clk_sys);
        #1 irq_request = 1'(r);
        @(negedge clk_sys);
        chk(w[4] ? (irq_out === 0 && irq_oe === r[0])
                 : (irq_oe === 1 && irq_out === r[0]), "interrupt pin");
      end
    end
    p = 7'($urandom);
    wr(ADDR_PAGE, {17'($urandom), p});
    chk(page_select === p, "page select");
    rd(ADDR_CTRL, w & CTRL_MASK);
    rd(5'h1A, ZERO24);
    peaks(8, 0);
    peaks(5, 4);
    rms_voltage = 24'hC00000;
    rms_current = 24'hC00000;
    active_power = 24'h300000;
    dft_v_re = 24'h400000;
    dft_i_re = 24'h400000;
    dft_v_im = 24'h200000;
    cycle_end = 1;
    @(posedge clk_sys);
    #1 cycle_end = 0;
    repeat (40) @(posedge clk_sys);
    wr(ADDR_APPAR, 24'hFFFFFF);
    // S = 0.75 * 0.75 = 0.5625, with the top bit always clear
    rd(ADDR_APPAR, 24'h480000);
    rd(ADDR_PFUND, 24'h200000);
    rd(ADDR_PHARM, 24'h100000);
    rd(ADDR_QFUND, 24'h100000);
    rd(ADDR_PFACT, 24'h555555);
    w = 24'(longint'($floor($sqrt(real'(24'h480000) ** 2 - real'(24'h300000) ** 2))));
    rd(ADDR_TRIG_REACTIVE_POWER, w);
    // Negative half-scale P against S of 0.0625: ratio out of range
    rms_voltage = 24'h400000;
    rms_current = 24'h400000;
    active_power = 24'hC00000;
    cycle_end = 1;
    @(posedge clk_sys);
    #1 cycle_end = 0;
    repeat (40) @(posedge clk_sys);
    rd(ADDR_PFACT, FRAC_MIN);
    rd(ADDR_TRIG_REACTIVE_POWER, ZERO24);
    rd(ADDR_PHARM, 24'hA00000);
    repeat (4) @(posedge clk_sys);
    chk(q.size() == 0, "missing read answers");
    summarize();
  end
endmodule
